// >>> verilog/timer_event_counter.sv
// 32-bit timer/event counter with prescaler, four match and four capture channels.
// Assumes a register master that keeps strobes one cycle long and never both at once.
// Behaviour
// (RULE1) Count peripheral clock or selected external edges
// (RULE2) 32-bit count behind a 32-bit prescaler
// (RULE3) Four 32-bit match registers compared with count
// (RULE4) Match continues, stops or resets; optional interrupt
// (RULE5) Four capture channels snapshot count on edges
// (RULE6) Event mode counts edges; pulses last one clock; the synchroniser filter drops levels held under two clocks
// (RULE7) Other capture inputs stay usable in event mode
// (RULE8) Match outputs go low, high, toggle or hold
// (RULE9) Pins OR/AND into captures; outputs broadcast
// (RULE10) Prescaler wraps at programmed value, count increments
// (RULE11) Interrupt flags sticky until written with one
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/1ns
module timer_event_counter (
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  input  wire timer_pkg::bus_req_s         bus,
  output logic      [31:0]                 rdata,
  input  wire logic [timer_pkg::NPIN-1:0]  cap_pin,
  output logic      [timer_pkg::NPIN-1:0]  mat_pin,
  output logic                             irq
);
  import timer_pkg::*;

  function automatic logic is_slot(input logic [7:0] addr, input logic [7:0] base,
                                   input int unsigned i);
    is_slot = (addr == 8'(base + 8'(4 * i)));
  endfunction

  function automatic logic ext_apply(input ext_e act, input logic cur);
    case (act)
      EXT_LOW:    ext_apply = 1'b0;
      EXT_HIGH:   ext_apply = 1'b1;
      EXT_TOGGLE: ext_apply = ~cur;
      default:    ext_apply = cur;
    endcase
  endfunction

  logic [5:0]      ctrl_r;
  logic [5:0]      ctrl_nxt;
  logic [31:0]     tc_r;
  logic [31:0]     tc_nxt;
  logic [31:0]     pr_r;
  logic [31:0]     pr_nxt;
  logic [31:0]     pc_r;
  logic [31:0]     pc_nxt;
  logic [11:0]     mcr_r;
  logic [11:0]     mcr_nxt;
  logic [31:0]     mr_r [NCH];
  logic [31:0]     mr_nxt [NCH];
  logic [11:0]     ccr_r;
  logic [11:0]     ccr_nxt;
  logic [31:0]     cr_r [NCH];
  logic [31:0]     cr_nxt [NCH];
  logic [11:0]     emr_r;
  logic [11:0]     emr_nxt;
  logic [7:0]      ist_r;
  logic [7:0]      ist_nxt;
  logic [7:0]      imask_r;
  logic [7:0]      imask_nxt;
  logic [11:0]     route_r;
  logic [11:0]     route_nxt;
  logic [NCH-1:0]  cprev_r;
  logic [NCH-1:0]  cprev_nxt;
  logic [31:0]     rdata_r;
  logic [31:0]     rdata_nxt;
  logic [NPIN-1:0] mat_r;
  logic [NPIN-1:0] mat_nxt;
  logic            irq_r;
  logic            irq_nxt;

  logic [NPIN-1:0] cap_lvl;
  logic [NCH-1:0]  chan_lvl;
  logic [NCH-1:0]  rise;
  logic [NCH-1:0]  fall;
  logic [NCH-1:0]  cap_ev;
  logic [NCH-1:0]  mhit;
  logic [NCH-1:0]  mint;
  logic [NCH-1:0]  mrst;
  logic [NCH-1:0]  mstop;
  logic [NCH-1:0]  cint;
  logic [1:0]      sel;
  src_e            mode;
  logic            running;
  logic            tick;
  logic            adv;

  cap_sync u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .pin_in   (cap_pin),
    .level    (cap_lvl)
  );

  assign sel = ctrl_r[CTRL_SEL +: 2];
  assign mode = src_e'(ctrl_r[CTRL_MODE +: 2]);
  assign running = ctrl_r[CTRL_EN] & ~ctrl_r[CTRL_RST];

  // Two pins per capture channel: enabled pins are ORed, or ANDed when the
  // channel's AND bit is set; an AND with no enabled pin stays low
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic [1:0] en;
    logic [1:0] pins;
    assign en = route_r[2*g +: 2];
    assign pins = cap_lvl[2*g +: 2];
    assign chan_lvl[g] = route_r[ROUTE_AND + g] ? (&(pins | ~en) & |en) // RULE9
                                                : |(pins & en); // RULE9
    assign rise[g] = chan_lvl[g] & ~cprev_r[g];
    assign fall[g] = ~chan_lvl[g] & cprev_r[g];
    assign cap_ev[g] = (ccr_r[3*g + CC_RISE] & rise[g])
                     | (ccr_r[3*g + CC_FALL] & fall[g]); // RULE5 RULE7
    assign cint[g] = ccr_r[3*g + CC_INT];
    assign mint[g] = mcr_r[3*g + MC_INT];
    assign mrst[g] = mcr_r[3*g + MC_RESET];
    assign mstop[g] = mcr_r[3*g + MC_STOP];
    assign mhit[g] = adv & (tc_r == mr_r[g]); // RULE3
  end

  // Count source: every clock, or edges of the selected capture channel
  always_comb begin
    case (mode)
      SRC_CLK:  tick = running; // RULE1
      SRC_RISE: tick = running & rise[sel]; // RULE1 RULE6
      SRC_FALL: tick = running & fall[sel]; // RULE6
      SRC_BOTH: tick = running & (rise[sel] | fall[sel]); // RULE6
      default:  tick = 1'b0;
    endcase
  end

  assign adv = tick & (pc_r == pr_r); // RULE10

  always_comb begin
    ctrl_nxt = ctrl_r;
    tc_nxt = tc_r;
    pr_nxt = pr_r;
    pc_nxt = pc_r;
    mcr_nxt = mcr_r;
    mr_nxt = mr_r;
    ccr_nxt = ccr_r;
    cr_nxt = cr_r;
    emr_nxt = emr_r;
    imask_nxt = imask_r;
    route_nxt = route_r;
    cprev_nxt = chan_lvl;
    rdata_nxt = RST_WORD;

    // Match reset wins over increment; a stop freezes the count after this edge
    if (adv) begin
      pc_nxt = RST_WORD; // RULE10
      tc_nxt = |(mhit & mrst) ? RST_WORD : tc_r + 32'h0000_0001; // RULE2 RULE4
    end else if (tick) begin
      pc_nxt = pc_r + 32'h0000_0001; // RULE2 RULE10
    end
    if (|(mhit & mstop)) begin
      ctrl_nxt[CTRL_EN] = 1'b0; // RULE4
    end
    if (ctrl_r[CTRL_RST]) begin
      tc_nxt = RST_WORD;
      pc_nxt = RST_WORD;
    end
    for (int i = 0; i < NCH; i++) begin
      if (cap_ev[i]) begin
        cr_nxt[i] = tc_r; // RULE5
      end
      if (mhit[i]) begin
        emr_nxt[i] = ext_apply(ext_e'(emr_r[EXT_ACT + 2*i +: 2]), emr_r[i]); // RULE8
      end
    end

    // Software writes override hardware updates, except on the flags
    ist_nxt = ist_r;
    if (bus.wr) begin
      case (bus.addr)
        A_CTRL:     ctrl_nxt = bus.wdata[5:0];
        A_COUNT:    begin
          tc_nxt = bus.wdata;
          pc_nxt = RST_WORD;
        end
        A_PRESCALE: pr_nxt = bus.wdata; // RULE2
        A_MCTRL:    mcr_nxt = bus.wdata[11:0]; // RULE4
        A_CCTRL:    ccr_nxt = bus.wdata[11:0];
        A_EXTOUT:   emr_nxt = bus.wdata[11:0]; // RULE8
        A_ISTAT:    ist_nxt = ist_r & ~bus.wdata[7:0]; // RULE11
        A_IMASK:    imask_nxt = bus.wdata[7:0];
        A_ROUTE:    route_nxt = bus.wdata[11:0]; // RULE9
        default:    ;
      endcase
      for (int i = 0; i < NCH; i++) begin
        if (is_slot(bus.addr, A_MATCH0, i)) begin
          mr_nxt[i] = bus.wdata; // RULE3
        end
      end
    end
    // A new event in the clearing cycle keeps its flag set
    ist_nxt = ist_nxt | {cap_ev & cint, mhit & mint}; // RULE4 RULE5 RULE11

    if (bus.rd) begin
      case (bus.addr)
        A_CTRL:     rdata_nxt = {26'h0, ctrl_r};
        A_COUNT:    rdata_nxt = tc_r;
        A_PRESCALE: rdata_nxt = pr_r;
        A_PCOUNT:   rdata_nxt = pc_r;
        A_MCTRL:    rdata_nxt = {20'h0, mcr_r};
        A_CCTRL:    rdata_nxt = {20'h0, ccr_r};
        A_EXTOUT:   rdata_nxt = {20'h0, emr_r};
        A_ISTAT:    rdata_nxt = {24'h0, ist_r};
        A_IMASK:    rdata_nxt = {24'h0, imask_r};
        A_ROUTE:    rdata_nxt = {20'h0, route_r};
        default:    rdata_nxt = RST_WORD;
      endcase
      for (int i = 0; i < NCH; i++) begin
        if (is_slot(bus.addr, A_MATCH0, i)) begin
          rdata_nxt = mr_r[i];
        end
        if (is_slot(bus.addr, A_CAPT0, i)) begin
          rdata_nxt = cr_r[i];
        end
      end
    end

    for (int i = 0; i < NCH; i++) begin
      mat_nxt[2*i] = emr_nxt[i]; // RULE8 RULE9
      mat_nxt[2*i+1] = emr_nxt[i]; // RULE9
    end
    irq_nxt = |(ist_nxt & imask_nxt);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= RST_CTRL;
      tc_r <= RST_WORD;
      pr_r <= RST_WORD;
      pc_r <= RST_WORD;
      mcr_r <= RST_FIELD;
      ccr_r <= RST_FIELD;
      emr_r <= RST_FIELD;
      ist_r <= RST_BYTE;
      imask_r <= RST_BYTE;
      route_r <= RST_ROUTE;
      cprev_r <= RST_BYTE[NCH-1:0];
      rdata_r <= RST_WORD;
      mat_r <= RST_BYTE;
      irq_r <= 1'b0;
      for (int i = 0; i < NCH; i++) begin
        mr_r[i] <= RST_WORD;
        cr_r[i] <= RST_WORD;
      end
    end else begin
      ctrl_r <= ctrl_nxt;
      tc_r <= tc_nxt;
      pr_r <= pr_nxt;
      pc_r <= pc_nxt;
      mcr_r <= mcr_nxt;
      ccr_r <= ccr_nxt;
      emr_r <= emr_nxt;
      ist_r <= ist_nxt;
      imask_r <= imask_nxt;
      route_r <= route_nxt;
      cprev_r <= cprev_nxt;
      rdata_r <= rdata_nxt;
      mat_r <= mat_nxt;
      irq_r <= irq_nxt;
      mr_r <= mr_nxt;
      cr_r <= cr_nxt;
    end
  end

  assign rdata = rdata_r;
  assign mat_pin = mat_r;
  assign irq = irq_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_clk_count;
    running && mode == SRC_CLK && pr_r == RST_WORD && mcr_r == RST_FIELD && !bus.wr
      |=> tc_r == $past(tc_r) + 32'h0000_0001;
  endproperty
  a_clk_count: assert property (p_clk_count) else $error("timer mode missed a count"); // RULE1

  property p_pre_hold;
    tick && pc_r != pr_r && !bus.wr |=> pc_r == $past(pc_r) + 32'h0000_0001 ##0
      tc_r == $past(tc_r);
  endproperty
  a_pre_hold: assert property (p_pre_hold) else $error("prescaler step wrong"); // RULE2

  property p_pre_wrap;
    adv && !(|(mhit & mrst)) && !bus.wr |=> pc_r == RST_WORD && tc_r == $past(tc_r) + 1;
  endproperty
  a_pre_wrap: assert property (p_pre_wrap) else $error("prescaler wrap wrong"); // RULE10

  property p_match_int;
    adv && tc_r == mr_r[0] && mint[0] |=> ist_r[0];
  endproperty
  a_match_int: assert property (p_match_int) else $error("match flag not set"); // RULE3

  property p_match_reset;
    adv && tc_r == mr_r[1] && mrst[1] && !bus.wr |=> tc_r == RST_WORD;
  endproperty
  a_match_reset: assert property (p_match_reset) else $error("match reset failed"); // RULE4

  property p_match_stop;
    adv && tc_r == mr_r[2] && mstop[2] && !bus.wr |=> !ctrl_r[CTRL_EN] ##1
      (tc_r == $past(tc_r) || $past(bus.wr));
  endproperty
  a_match_stop: assert property (p_match_stop) else $error("match stop failed"); // RULE4

  property p_capture;
    rise[1] && ccr_r[3 + CC_RISE] |=> cr_r[1] == $past(tc_r);
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong"); // RULE5

  property p_event_idle;
    running && mode == SRC_RISE && !rise[sel] && !bus.wr
      |=> pc_r == $past(pc_r) && tc_r == $past(tc_r);
  endproperty
  a_event_idle: assert property (p_event_idle) else $error("count without edge"); // RULE6

  property p_other_capture;
    mode != SRC_CLK && sel != 2'b01 && cap_ev[1]
      |=> cr_r[1] == $past(tc_r);
  endproperty
  a_other_capture: assert property (p_other_capture) else $error("side capture lost"); // RULE7

  property p_toggle;
    mhit[2] && emr_r[EXT_ACT + 4 +: 2] == EXT_TOGGLE && !bus.wr |=> mat_r[4] != $past(mat_r[4]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("match output not toggled"); // RULE8

  property p_broadcast;
    mat_r[0] == mat_r[1] && mat_r[2] == mat_r[3] && mat_r[4] == mat_r[5] && mat_r[6] == mat_r[7];
  endproperty
  a_broadcast: assert property (p_broadcast) else $error("broadcast pins differ"); // RULE9

  property p_sticky;
    ist_r[IST_CAP + 1] && !(bus.wr && bus.addr == A_ISTAT && bus.wdata[IST_CAP + 1])
      |=> ist_r[IST_CAP + 1];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped"); // RULE11

  c_match_reset: cover property (adv && |(mhit & mrst));
  c_capture: cover property (|cap_ev);
  c_irq: cover property (irq_r);
  c_event_tick: cover property (mode != SRC_CLK && tick);

endmodule

// >>> verilog/timer_pkg.sv
// Shared constants, register map and carrier types for the timer/event counter.
// Assumes a 20 MHz core clock and a plain strobe register port.
package timer_pkg;

  localparam int unsigned NCH = 4;
  localparam int unsigned NPIN = 8;
  localparam int unsigned SYNC_STAGES = 3;

  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_COUNT = 8'h04;
  localparam logic [7:0] A_PRESCALE = 8'h08;
  localparam logic [7:0] A_PCOUNT = 8'h0c;
  localparam logic [7:0] A_MCTRL = 8'h10;
  localparam logic [7:0] A_MATCH0 = 8'h14;
  localparam logic [7:0] A_CCTRL = 8'h24;
  localparam logic [7:0] A_CAPT0 = 8'h28;
  localparam logic [7:0] A_EXTOUT = 8'h38;
  localparam logic [7:0] A_ISTAT = 8'h3c;
  localparam logic [7:0] A_IMASK = 8'h40;
  localparam logic [7:0] A_ROUTE = 8'h44;

  // Control fields
  localparam int unsigned CTRL_EN = 0;
  localparam int unsigned CTRL_RST = 1;
  localparam int unsigned CTRL_MODE = 2;
  localparam int unsigned CTRL_SEL = 4;

  // Per-channel field positions inside the 3-bit groups, then base bits of the extout, route and flag fields
  localparam int unsigned MC_INT = 0;
  localparam int unsigned MC_RESET = 1;
  localparam int unsigned MC_STOP = 2;
  localparam int unsigned CC_RISE = 0;
  localparam int unsigned CC_FALL = 1;
  localparam int unsigned CC_INT = 2;
  localparam int unsigned EXT_ACT = 4;
  localparam int unsigned ROUTE_AND = 8;
  localparam int unsigned IST_CAP = 4;

  // Values after reset
  localparam logic [5:0] RST_CTRL = 6'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [11:0] RST_FIELD = 12'h000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [11:0] RST_ROUTE = 12'h055;

  typedef enum logic [1:0] {
    SRC_CLK  = 2'b00,
    SRC_RISE = 2'b01,
    SRC_FALL = 2'b10,
    SRC_BOTH = 2'b11
  } src_e;

  typedef enum logic [1:0] {
    EXT_NONE   = 2'b00,
    EXT_LOW    = 2'b01,
    EXT_HIGH   = 2'b10,
    EXT_TOGGLE = 2'b11
  } ext_e;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } bus_req_s;

endpackage

// >>> verilog/cap_sync.sv
// Three-stage synchroniser with agreement filter for the capture pins.
// Assumes the pins are asynchronous to core_clk.
`timescale 1ns/1ns
module cap_sync (
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  input  wire logic [timer_pkg::NPIN-1:0]  pin_in,
  output logic      [timer_pkg::NPIN-1:0]  level
);
  import timer_pkg::*;

  logic [NPIN-1:0] s1_r;
  logic [NPIN-1:0] s2_r;
  logic [NPIN-1:0] s3_r;
  logic [NPIN-1:0] lvl_r;
  logic [NPIN-1:0] lvl_nxt;

  // Level only moves once stages two and three agree, so a one-cycle
  // metastable glitch never reaches the edge detectors
  always_comb begin
    lvl_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & lvl_r);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_r <= RST_BYTE;
      s2_r <= RST_BYTE;
      s3_r <= RST_BYTE;
      lvl_r <= RST_BYTE;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  assign level = lvl_r;

endmodule

// >>> test/far_side.sv
// Far-side model: drives the capture pins and watches the match outputs.
// Assumes pulse() is called just after a rising core_clk edge.
`timescale 1ns/1ns
module far_side
  import timer_pkg::*;
(
  input  wire logic                        core_clk,
  output logic      [timer_pkg::NPIN-1:0]  cap_pin,
  input  wire logic [timer_pkg::NPIN-1:0]  mat_pin,
  output int                               bad
);
  initial begin
    cap_pin = '0;
    bad = 0;
  end

  // Levels change only at clock edges and last whole cycles, never under one
  task automatic pulse(input logic [NPIN-1:0] m, input int hi, input int lo);
    cap_pin <= m;
    repeat (hi) @(posedge core_clk);
    cap_pin <= '0;
    repeat (lo) @(posedge core_clk);
  endtask

  // Both pins of one match channel must always agree
  always @(negedge core_clk) begin
    for (int i = 0; i < NCH; i++) begin
      if (mat_pin[2*i] !== mat_pin[2*i+1]) begin
        bad <= bad + 1;
      end
    end
  end
endmodule

// >>> test/tb_top.sv
// Self-checking bench for the timer/event counter.
// Assumes the register map of timer_pkg and a 20 MHz core clock.
`timescale 1ns/1ns
module tb_top;
  import timer_pkg::*;
  logic             core_clk;
  logic             rst;
  bus_req_s         bus;
  logic [31:0]      rdata;
  logic [NPIN-1:0]  cap_pin;
  logic [NPIN-1:0]  mat_pin;
  logic             irq;
  int               bad;
  int               errors;
  int               n_compared;
  int               cyc;
  int               p;
  int               m;
  int               n;
  int               tk;
  logic [31:0]      lfsr;
  logic [31:0]      v;
  logic [31:0]      c0;

  timer_event_counter u_dut (.core_clk(core_clk), .rst(rst), .bus(bus), .rdata(rdata),
    .cap_pin(cap_pin), .mat_pin(mat_pin), .irq(irq));
  far_side u_far (.core_clk(core_clk), .cap_pin(cap_pin), .mat_pin(mat_pin), .bad(bad));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  function automatic logic [7:0] bcast(input logic [3:0] s);
    for (int i = 0; i < 8; i++) bcast[i] = s[i/2];
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Each access is followed by an idle cycle so no signal is assigned twice at once
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk);
    bus <= '0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge core_clk);
    bus <= '0;
    #1 d = rdata;
    @(posedge core_clk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  task automatic summarize();
    chk(32'(bad), 32'h0);
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Whole run needs under a thousand cycles; the ceiling leaves wide margin
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      summarize();
    end
  end

  initial begin
    bus = '0;
    rst = 1'b1;
    errors = 0;
    n_compared = 0;
    cyc = 0;
    lfsr = 32'h54811df4;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    chk(32'(irq), 32'h0);
    chk(32'(mat_pin), 32'h0);
    rchk(A_ROUTE, 32'h55);
    rchk(A_COUNT, 32'h0);
    wr(8'h80, 32'hffffffff);
    rchk(8'h80, 32'h0);
    $display("test reset done");

    // All four matches at one random value; channels 0 and 2 stop the count
    p = int'(rnd() % 4);
    m = 20 + int'(rnd() % 40);
    wr(A_COUNT, 32'h0);
    wr(A_PRESCALE, 32'(p));
    for (int i = 0; i < NCH; i++) wr(A_MATCH0 + 8'(4*i), 32'(m));
    wr(A_MCTRL, 32'h34d);
    wr(A_EXTOUT, 32'h395);
    wr(A_IMASK, 32'h0);
    wr(A_ISTAT, 32'hff);
    chk(32'(mat_pin), 32'(bcast(4'h5)));
    wr(A_CTRL, 32'h1);
    v = '0;
    for (int k = 0; k < 500 && !v[0]; k++) rd(A_ISTAT, v);
    // The stopping advance still steps the count once
    rchk(A_COUNT, 32'(m + 1));
    rchk(A_CTRL, 32'h0);
    rchk(A_ISTAT, 32'hf);
    chk(32'(mat_pin), 32'(bcast(4'h2)));
    rchk(A_EXTOUT, 32'h392);
    chk(32'(irq), 32'h0);
    wr(A_IMASK, 32'h1);
    repeat (2) @(posedge core_clk);
    chk(32'(irq), 32'h1);
    wr(A_ISTAT, 32'h0);
    rchk(A_ISTAT, 32'hf);
    wr(A_ISTAT, 32'h1);
    rchk(A_ISTAT, 32'he);
    chk(32'(irq), 32'h0);
    $display("test match stop done");

    // Corner case: reset at five with no prescale
    wr(A_ISTAT, 32'hff);
    wr(A_MCTRL, 32'h18);
    wr(A_MATCH0 + 8'h04, 32'h5);
    wr(A_PRESCALE, 32'h0);
    wr(A_COUNT, 32'h0);
    wr(A_CTRL, 32'h1);
    for (int k = 0; k < 8; k++) begin
      rd(A_COUNT, v);
      chk(32'(v <= 32'h5), 32'h1);
    end
    wr(A_CTRL, 32'h0);
    rchk(A_ISTAT, 32'h2);
    $display("test match reset done");

    // Capture with OR routing on channel 1, AND routing on channel 2
    for (int i = 0; i < NCH; i++) wr(A_MATCH0 + 8'(4*i), 32'hffffffff);
    wr(A_MCTRL, 32'h0);
    wr(A_CCTRL, 32'h178);
    wr(A_ROUTE, 32'h47d);
    wr(A_ISTAT, 32'hff);
    wr(A_CTRL, 32'h1);
    rd(A_COUNT, c0);
    u_far.pulse(8'h08, 4, 8);
    rd(A_CAPT0 + 8'h4, v);
    chk(32'(v > c0 && v < c0 + 32'd30), 32'h1);
    rchk(A_ISTAT, 32'h20);
    u_far.pulse(8'h10, 4, 8);
    rchk(A_ISTAT, 32'h20);
    u_far.pulse(8'h30, 4, 8);
    rchk(A_ISTAT, 32'h60);
    wr(A_CTRL, 32'h0);
    $display("test capture done");

    // Event counting on channel 3 for each edge mode, channel 1 still captures
    for (int md = 1; md < 4; md++) begin
      p = int'(rnd() % 3);
      n = 5 + int'(rnd() % 8);
      tk = (md == 3) ? 2 * n : n;
      wr(A_CTRL, 32'h2);
      wr(A_PRESCALE, 32'(p));
      wr(A_ISTAT, 32'hff);
      wr(A_CTRL, 32'h31 | 32'(md << 2));
      for (int k = 0; k < n; k++) begin
        u_far.pulse((k == 2) ? 8'h44 : 8'h40, 3 + int'(rnd() % 4), 3 + int'(rnd() % 4));
      end
      repeat (10) @(posedge core_clk);
      wr(A_CTRL, 32'h0);
      rchk(A_COUNT, 32'(tk / (p + 1)));
      rchk(A_PCOUNT, 32'(tk % (p + 1)));
      rchk(A_ISTAT, 32'h20);
    end
    $display("test event count done");
    summarize();
  end
endmodule
